// ### common/mac_consts.svh
// Purpose: Constants of the magnetic angle conditioning block
// Assumes: Included by bare name, definitions only
// Notes:   Offsets are Wishbone byte addresses of 32-bit words
`ifndef MAC_CONSTS_SVH
`define MAC_CONSTS_SVH

// Clock and sample timing
`define MAC_CLK_HZ       40000000
`define MAC_SAMPLE_HZ    1000000
`define MAC_SAMPLE_CYC   (`MAC_CLK_HZ / `MAC_SAMPLE_HZ)
`define MAC_TDC_SCALE    (65536 / `MAC_SAMPLE_CYC)

// Filter: tau = 0.38 / 93 Hz = 4.086 ms, w = 1/tau = 244.7 rad/s
// Per 1 us sample: 2*w*Ts = 4.89e-4 ~ 2^-11, (w*Ts)^2 = 5.99e-8 ~ 2^-24
`define MAC_FCUT_HZ      93
`define MAC_FRAC_W       24
`define MAC_K1_SHIFT     11
`define MAC_ERR_SHIFT    (`MAC_FRAC_W - `MAC_K1_SHIFT)

// Register offsets
`define MAC_REG_CTRL     8'h00
`define MAC_REG_ZERO     8'h04
`define MAC_REG_COMP     8'h08
`define MAC_REG_LOW_THR  8'h0C
`define MAC_REG_HIGH_THR 8'h10
`define MAC_REG_HYST     8'h14
`define MAC_REG_ANGLE    8'h18
`define MAC_REG_FIELD    8'h1C
`define MAC_REG_IRQ_STAT 8'h20
`define MAC_REG_IRQ_MASK 8'h24

// Field positions
`define MAC_CTRL_DIR     0
`define MAC_CTRL_COMP    1
`define MAC_EV_ANGLE     0
`define MAC_EV_LOW       1
`define MAC_EV_HIGH      2

// Reset values
`define MAC_RST_CTRL     2'h0
`define MAC_RST_ZERO     16'h0000
`define MAC_RST_COMP     8'h00
`define MAC_RST_LOW_THR  8'h20
`define MAC_RST_HIGH_THR 8'h60
`define MAC_RST_HYST     8'h06
`define MAC_RST_MASK     3'h0

`endif

// ### common/mac_pkg.sv
// Purpose: Types of the magnetic angle conditioning block
// Assumes: Widths fixed by the packed state record
// Notes:   Position and velocity carry 24 fraction bits
package mac_pkg;

	// Whole state of the block, registered in one process
	typedef struct packed {
		logic [7:0]  tdc_cnt;
		logic [15:0] raw;
		logic        raw_vld;
		logic [39:0] pos;
		logic [39:0] vel;
		logic        filt_vld;
		logic [15:0] angle;
		logic        angle_vld;
		logic        low_flag;
		logic        high_flag;
		logic [1:0]  ctrl;
		logic [15:0] zero;
		logic [7:0]  comp;
		logic [7:0]  low_thr;
		logic [7:0]  high_thr;
		logic [7:0]  hyst;
		logic [2:0]  irq_stat;
		logic [2:0]  irq_mask;
		logic        irq;
		logic        ack;
		logic [31:0] dat;
	} mac_state_t;

endpackage

// ### rtl/mac_top.sv
// Purpose: Angle conditioning behind the time-to-digital front-end
// Assumes: All inputs synchronous to clk_i; one Wishbone classic slave
// Notes:   Angle words are 16 bits, one full magnetic turn per wrap
//
// Behaviour
// - Each raw angle is the cycle count from sinusoid zero crossing to reference edge, scaled by 65536/40 to a 16-bit turn.
// - A new raw angle enters the conditioning once per 1 MHz period, open loop.
// - The stream is filtered by (1 + 2*tau*s) / (1 + tau*s)^2 with tau = 0.38 / cutoff.
// - The filter adds no lag while the rotation speed is constant.
// - The cutoff used for tau is 93 Hz.
// - With default settings the angle grows as the field turns clockwise.
// - Direction can be reversed and the zero angle offset by software.
// - The low field flag is raised while the field is below the low threshold.
// - The high field flag is raised while the field is above the high threshold.
// - A programmable correction restores linearity for off-axis magnets.
// - The output is the field angle, wrapping once per pole pair.
`timescale 1ns/10ps
`include "mac_consts.svh"

module mac_top (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,

	// Front-end timing and field strength
	input  wire logic        zero_cross_i,
	input  wire logic        ref_edge_i,
	input  wire logic [7:0]  field_i,

	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,

	// Conditioned angle
	output logic      [15:0] angle_o,
	output logic             angle_valid_o,

	// Field flags and interrupt
	output logic             low_field_flag_o,
	output logic             high_field_flag_o,
	output logic             irq_o
);

	// Present and next state
	mac_pkg::mac_state_t s;
	mac_pkg::mac_state_t next_s;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old,
		input logic [31:0] din,
		input logic [3:0]  sel
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = din[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Triangle of period one half turn, centred on zero
	function automatic logic signed [14:0] half_turn_tri(
		input logic [15:0] a
	);
		logic [13:0] p;
		p = a[14] ? ~a[13:0] : a[13:0];
		return $signed({1'b0, p}) - 15'sh2000;
	endfunction

	// Combinational working values
	logic signed [15:0] err;
	logic        [39:0] err_ext;
	logic        [15:0] a;
	logic signed [23:0] prod;
	logic        [2:0]  ev;
	logic        [2:0]  clr;
	logic        [31:0] wd;
	logic        [8:0]  low_rel;
	logic        [8:0]  high_rel;

	// Next-state logic for the whole block
	always_comb begin
		next_s   = s;
		err      = 16'sh0000;
		err_ext  = 40'h00_0000_0000;
		a        = 16'h0000;
		prod     = 24'sh00_0000;
		ev       = 3'h0;
		clr      = 3'h0;
		wd       = 32'h0000_0000;
		low_rel  = 9'h000;
		high_rel = 9'h000;

		// Strobes last one cycle
		next_s.ack       = 1'b0;
		next_s.raw_vld   = 1'b0;
		next_s.filt_vld  = 1'b0;
		next_s.angle_vld = 1'b0;

		// Time-to-digital: count from zero crossing, held at the period end
		if (zero_cross_i) begin
			next_s.tdc_cnt = 8'h00;
		end else if (s.tdc_cnt != 8'(`MAC_SAMPLE_CYC - 1)) begin
			next_s.tdc_cnt = s.tdc_cnt + 8'h01;
		end

		// Reference edge closes the measurement, one word per period
		if (ref_edge_i) begin
			next_s.raw     = 16'(32'(s.tdc_cnt) * `MAC_TDC_SCALE);
			next_s.raw_vld = 1'b1;
		end

		// Critically damped type-2 tracker: zero lag at constant speed
		// Wrapped error keeps the tracker sane across the 0/360 seam
		if (s.raw_vld) begin
			err            = $signed(s.raw - s.pos[39:24]);
			err_ext        = {{24{err[15]}}, err};
			next_s.vel     = s.vel + err_ext;
			next_s.pos     = s.pos + s.vel + (err_ext << `MAC_ERR_SHIFT);
			next_s.filt_vld = 1'b1;
		end

		// Direction, zero offset, off-axis correction on the filtered word
		if (s.filt_vld) begin
			a = s.pos[39:24];
			if (s.ctrl[`MAC_CTRL_DIR]) begin
				a = 16'h0000 - a;
			end
			a = a - s.zero;
			if (s.ctrl[`MAC_CTRL_COMP]) begin
				prod = $signed(s.comp) * half_turn_tri(a);
				a    = a + 16'(prod[23:8]);
			end
			// Field angle as is: no pole-pair division
			next_s.angle     = a;
			next_s.angle_vld = 1'b1;
		end

		// Low flag: set below threshold, clear at threshold plus hysteresis
		low_rel = {1'b0, s.low_thr} + {1'b0, s.hyst};
		if (!s.low_flag && (field_i < s.low_thr)) begin
			next_s.low_flag = 1'b1;
		end else if (s.low_flag && ({1'b0, field_i} >= low_rel)) begin
			next_s.low_flag = 1'b0;
		end

		// High flag: set above threshold, clear at threshold minus hysteresis
		high_rel = {1'b0, field_i} + {1'b0, s.hyst};
		if (!s.high_flag && (field_i > s.high_thr)) begin
			next_s.high_flag = 1'b1;
		end else if (s.high_flag && (high_rel <= {1'b0, s.high_thr})) begin
			next_s.high_flag = 1'b0;
		end

		// Events: new angle, rising low flag, rising high flag
		ev[`MAC_EV_ANGLE] = next_s.angle_vld;
		ev[`MAC_EV_LOW]   = next_s.low_flag & ~s.low_flag;
		ev[`MAC_EV_HIGH]  = next_s.high_flag & ~s.high_flag;

		// Bus access, answered one cycle after the request
		if (wb_cyc_i && wb_stb_i && !s.ack) begin
			next_s.ack = 1'b1;
			if (wb_we_i) begin
				unique case (wb_adr_i)
					`MAC_REG_CTRL: begin
						wd          = lane_merge({30'h0, s.ctrl}, wb_dat_i, wb_sel_i);
						next_s.ctrl = wd[1:0];
					end
					`MAC_REG_ZERO: begin
						wd          = lane_merge({16'h0000, s.zero}, wb_dat_i, wb_sel_i);
						next_s.zero = wd[15:0];
					end
					`MAC_REG_COMP: begin
						wd          = lane_merge({24'h00_0000, s.comp}, wb_dat_i, wb_sel_i);
						next_s.comp = wd[7:0];
					end
					`MAC_REG_LOW_THR: begin
						wd             = lane_merge({24'h00_0000, s.low_thr}, wb_dat_i, wb_sel_i);
						next_s.low_thr = wd[7:0];
					end
					`MAC_REG_HIGH_THR: begin
						wd              = lane_merge({24'h00_0000, s.high_thr}, wb_dat_i,
							wb_sel_i);
						next_s.high_thr = wd[7:0];
					end
					`MAC_REG_HYST: begin
						wd          = lane_merge({24'h00_0000, s.hyst}, wb_dat_i, wb_sel_i);
						next_s.hyst = wd[7:0];
					end
					`MAC_REG_IRQ_STAT: begin
						clr = wb_sel_i[0] ? wb_dat_i[2:0] : 3'h0;
					end
					`MAC_REG_IRQ_MASK: begin
						wd              = lane_merge({29'h0, s.irq_mask}, wb_dat_i, wb_sel_i);
						next_s.irq_mask = wd[2:0];
					end
					default: begin
						// Read-only or unmapped: write dropped, still acknowledged
						wd = 32'h0000_0000;
					end
				endcase
				next_s.dat = 32'h0000_0000;
			end else begin
				unique case (wb_adr_i)
					`MAC_REG_CTRL:     next_s.dat = {30'h0, s.ctrl};
					`MAC_REG_ZERO:     next_s.dat = {16'h0000, s.zero};
					`MAC_REG_COMP:     next_s.dat = {24'h00_0000, s.comp};
					`MAC_REG_LOW_THR:  next_s.dat = {24'h00_0000, s.low_thr};
					`MAC_REG_HIGH_THR: next_s.dat = {24'h00_0000, s.high_thr};
					`MAC_REG_HYST:     next_s.dat = {24'h00_0000, s.hyst};
					`MAC_REG_ANGLE:    next_s.dat = {16'h0000, s.angle};
					`MAC_REG_FIELD: begin
						next_s.dat = {14'h0, s.high_flag, s.low_flag, 8'h00, field_i};
					end
					`MAC_REG_IRQ_STAT: next_s.dat = {29'h0, s.irq_stat};
					`MAC_REG_IRQ_MASK: next_s.dat = {29'h0, s.irq_mask};
					default:           next_s.dat = 32'h0000_0000;
				endcase
			end
		end

		// Sticky status: a new event beats a clear in the same cycle
		next_s.irq_stat = (s.irq_stat & ~clr) | ev;
		next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);
	end

	// State register; reset puts settings to defaults
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s          <= '0;
			s.ctrl     <= `MAC_RST_CTRL;
			s.zero     <= `MAC_RST_ZERO;
			s.comp     <= `MAC_RST_COMP;
			s.low_thr  <= `MAC_RST_LOW_THR;
			s.high_thr <= `MAC_RST_HIGH_THR;
			s.hyst     <= `MAC_RST_HYST;
			s.irq_mask <= `MAC_RST_MASK;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign wb_dat_o          = s.dat;
	assign wb_ack_o          = s.ack;
	assign angle_o           = s.angle;
	assign angle_valid_o     = s.angle_vld;
	assign low_field_flag_o  = s.low_flag;
	assign high_field_flag_o = s.high_flag;
	assign irq_o             = s.irq;

endmodule

// ### tb/mac_chk.sv
// Purpose: Port checker for the angle conditioning block
// Assumes: Bound into mac_top, single clock
// Notes:   Thresholds are internal, so flags are seen via the field word
`timescale 1ns/10ps
`include "mac_consts.svh"
module mac_chk (
	// Clock, reset and inputs
	input wire logic        clk_i, rst_i, ref_edge_i, wb_cyc_i, wb_stb_i, wb_we_i,
	input wire logic [7:0]  field_i, wb_adr_i,
	// Outputs
	input wire logic [31:0] wb_dat_o,
	input wire logic [15:0] angle_o,
	input wire logic        wb_ack_o, angle_valid_o, low_field_flag_o, high_field_flag_o, irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Bus answers with one registered pulse
	ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus ack missing");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack held");
	write_data_a: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
		else $error("data after write");
	// Each reference edge gives one new angle, three cycles on
	valid_delay_a: assert property (ref_edge_i |-> ##3 angle_valid_o)
		else $error("angle update missing");
	valid_cause_a: assert property (angle_valid_o |-> $past(ref_edge_i, 3))
		else $error("angle update without edge");
	angle_hold_a: assert property (!angle_valid_o |-> $stable(angle_o))
		else $error("angle moved between updates");
	// Field word carries level and both flags
	field_read_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == `MAC_REG_FIELD)
		|-> wb_dat_o[17:0] == $past({high_field_flag_o, low_field_flag_o, 8'h00, field_i}))
		else $error("field word wrong");
	// Interrupt only falls with the ack of a mask or clear write, both launched by one edge
	irq_drop_a: assert property ($fell(irq_o) |-> wb_ack_o)
		else $error("irq fell alone");
	cover property ($rose(irq_o));
	cover property ($rose(low_field_flag_o));
	cover property ($rose(high_field_flag_o));
endmodule
bind mac_top mac_chk mac_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .ref_edge_i(ref_edge_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .field_i(field_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .angle_o(angle_o), .wb_ack_o(wb_ack_o),
	.angle_valid_o(angle_valid_o), .low_field_flag_o(low_field_flag_o),
	.high_field_flag_o(high_field_flag_o), .irq_o(irq_o));

// ### tb/mac_fe_model.sv
// Purpose: Front-end stand-in with crossings, reference edges and field
// Assumes: Sample period of 40 clocks
// Notes:   Phase 1..39 sets the counted span
`timescale 1ns/10ps
module mac_fe_model (
	// Clock, reset and settings
	input  wire logic       clk_i, rst_i,
	input  wire logic [5:0] phase_i,
	input  wire logic [7:0] field_set_i,
	// Front-end outputs
	output logic            zero_cross_o = 1'b0,
	output logic            ref_edge_o = 1'b0,
	output logic      [7:0] field_o = 8'h40
);
	logic [5:0] cnt = 6'h00;
	// Open loop: one crossing and one edge per period
	always @(posedge clk_i) begin
		cnt <= (rst_i || cnt == 6'h27) ? 6'h00 : cnt + 6'h01;
		zero_cross_o <= !rst_i && cnt == 6'h00;
		ref_edge_o <= !rst_i && cnt == phase_i;
		field_o <= field_set_i;
	end
endmodule

// ### tb/mac_top_bench.sv
// Purpose: Self-checking bench for the angle conditioning block
// Assumes: Front-end model drives the sensor inputs
// Notes:   Filter settles over ms, so angle checks allow a tolerance
`timescale 1ns/10ps
`include "mac_consts.svh"
module mac_top_bench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00, fset = 8'h40, v;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic        zc, re, ack, av, lo, hi, irq;
	logic [7:0]  fld;
	logic [15:0] ang, a0;
	logic [1:0]  fl;
	int          failures = 0, checks_done = 0, seed = 32'h61ab;
	logic [7:0]  radr [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h24, 8'h30};
	logic [31:0] rval [8] = '{32'h0, 32'h0, 32'h0, 32'h20, 32'h60, 32'h6, 32'h0, 32'h0};
	logic [7:0]  cor [8] = '{8'h22, 8'h26, 8'h21, 8'h61, 8'h5c, 8'h5a, 8'h5f, 8'h1f};
	// 40 MHz clock
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	mac_fe_model mac_fe_model_inst (.clk_i(clk_i), .rst_i(rst_i), .phase_i(6'h0a),
		.field_set_i(fset), .zero_cross_o(zc), .ref_edge_o(re), .field_o(fld));
	mac_top mac_top_inst (.clk_i(clk_i), .rst_i(rst_i), .zero_cross_i(zc), .ref_edge_i(re),
		.field_i(fld), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .angle_o(ang),
		.angle_valid_o(av), .low_field_flag_o(lo), .high_field_flag_o(hi), .irq_o(irq));
	// Verdict, the single exit
	task automatic end_sim();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Exact when t is 0, else a wrapped angle distance since the filter keeps moving
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, input int t);
		logic signed [15:0] d;
		d = g[15:0] - e[15:0];
		checks_done++;
		if ((t == 0 ? g !== e : (d < -t || d > t)) !== 1'b0) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Bounded wait for ack or a new angle
	task automatic await(input logic on_valid);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((on_valid ? av : ack) !== 1'b1 && n < 100);
		if (n >= 100) begin
			failures++;
			end_sim();
		end
	endtask
	// Classic cycle held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		await(1'b0);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	// Expected {high, low} with hysteresis at reset thresholds
	function automatic logic [1:0] flags(input logic [7:0] f, input logic [1:0] p);
		logic [1:0] r;
		r[0] = (f < 8'h20) ? 1'b1 : (f >= 8'h26) ? 1'b0 : p[0];
		r[1] = (f > 8'h60) ? 1'b1 : ({1'b0, f} + 9'h006 <= 9'h060) ? 1'b0 : p[1];
		return r;
	endfunction
	// Main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, radr[i], 32'h0);
			chk("reg reset", rval[i], q, 0);
		end
		bus(1'b0, `MAC_REG_FIELD, 32'h0);
		chk("field word", 32'h40, q, 0);
		// Rise as the filter settles on the fixed phase, then zero offset, then reversal
		await(1'b1);
		a0 = ang;
		repeat (3) await(1'b1);
		chk("angle rising", 32'h1, {31'h0, ang > a0}, 0);
		a0 = ang;
		bus(1'b1, `MAC_REG_ZERO, 32'h4000);
		repeat (2) await(1'b1);
		chk("zero offset", {16'h0, a0 - 16'h4000}, {16'h0, ang}, 96);
		bus(1'b1, `MAC_REG_CTRL, 32'h1);
		repeat (2) await(1'b1);
		chk("reversed", {16'h0, 16'h0 - a0 - 16'h4000}, {16'h0, ang}, 96);
		bus(1'b1, `MAC_REG_CTRL, 32'h0);
		// Interrupt raised, masked, then cleared
		bus(1'b1, `MAC_REG_IRQ_MASK, 32'h1);
		await(1'b1);
		repeat (2) @(posedge clk_i);
		chk("irq angle", 32'h1, {31'h0, irq}, 0);
		bus(1'b1, `MAC_REG_IRQ_MASK, 32'h2);
		bus(1'b1, `MAC_REG_IRQ_STAT, 32'h7);
		@(posedge clk_i);
		chk("irq masked", 32'h0, {31'h0, irq}, 0);
		fset <= 8'h10;
		repeat (6) @(posedge clk_i);
		chk("irq low", 32'h1, {31'h0, irq}, 0);
		bus(1'b1, `MAC_REG_IRQ_STAT, 32'h2);
		@(posedge clk_i);
		chk("irq cleared", 32'h0, {31'h0, irq}, 0);
		// Threshold corners, then random levels
		fl = 2'b01;
		for (int i = 0; i < 40; i++) begin
			v = (i < 8) ? cor[i] : 8'($random(seed));
			fset <= v;
			fl = flags(v, fl);
			repeat (3) @(posedge clk_i);
			chk("flags", {30'h0, fl}, {30'h0, hi, lo}, 0);
		end
		end_sim();
	end
endmodule
